//--- rtl/cfi_flags.sv
// Flag, interrupt and return-stack logic of the tuning microcomputer core.
// Assumes pins are synchronous to pclk and that one op arrives per op_valid pulse.
module cfi_flags #(
	parameter int PERIOD_CYC = cfi_pkg::INTERVAL_CYC,
	parameter int HIGH_CYC   = cfi_pkg::HIGH_CYC
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	cfi_if.dev         itf,
	input  wire logic  irq_pin_n,
	input  wire logic  ce_pin,
	input  wire logic  unlock_pulse,
	output logic       interval_pulse,
	output logic [2:0] port_sel,
	output logic [3:0] flag_read_word,
	output logic       stack_err
);
	typedef struct packed {
		logic [15:0]      cnt;
		logic             pulse;
		logic             unlock;
		logic             carry;
		logic             bank;
		logic             inte;
		logic             int_req;
		logic             seen_high;
		logic             pin_prev;
		logic             ce_prev;
		logic [2:0][10:0] stk_addr;
		logic [2:0]       stk_skip;
		logic [1:0]       sp;
		logic             stk_err;
		logic [2:0]       port_sel;
		logic             res_valid;
		logic             res_true;
		logic             res_skip;
		logic             res_irq;
		logic [10:0]      res_addr;
	} cfi_dev_t;

	localparam logic [15:0] PERIOD_LAST = 16'(PERIOD_CYC - 1);
	localparam logic [15:0] HIGH_LEN    = 16'(HIGH_CYC);

	cfi_dev_t r_reg;
	cfi_dev_t r_next;

	// Masked set or clear of one status-word bit
	function automatic logic mask_apply(input logic cur, input logic sel, input logic set);
		mask_apply = sel ? set : cur;
	endfunction

	logic        pin_eff;
	logic        int_edge;
	logic        req_clear;
	logic        accept;
	logic [10:0] pop_addr;
	logic        pop_skip;
	logic [10:0] push_addr;
	logic [3:0]  rd_word;

	// Effective pin level; a low pin counts as high until it was once high
	assign pin_eff  = irq_pin_n | ~r_reg.seen_high; // R20
	assign int_edge = r_reg.pin_prev & ~pin_eff;    // R12
	assign rd_word  = {1'b0, r_reg.bank, ce_pin, ~pin_eff}; // R22

	// Top of the stack, valid only while sp is non-zero
	assign pop_addr = (r_reg.sp != 2'h0) ? r_reg.stk_addr[r_reg.sp - 2'h1] : 11'h000;
	assign pop_skip = (r_reg.sp != 2'h0) ? r_reg.stk_skip[r_reg.sp - 2'h1] : 1'b0;

	always_comb begin
		r_next           = r_reg;
		r_next.res_valid = 1'b0;
		r_next.res_irq   = 1'b0;
		r_next.res_true  = 1'b0;
		req_clear        = 1'b0;
		accept           = 1'b0;
		push_addr        = itf.op_addr;

		// Free-running interval pulse; no latch, tests read the live level
		r_next.cnt   = (r_reg.cnt >= PERIOD_LAST) ? 16'h0000 : r_reg.cnt + 16'h0001; // R01
		r_next.pulse = r_next.cnt < HIGH_LEN; // R01

		r_next.seen_high = r_reg.seen_high | irq_pin_n; // R20
		r_next.pin_prev  = pin_eff;
		r_next.ce_prev   = ce_pin;

		if (itf.op_valid) begin
			r_next.res_valid = 1'b1;
			r_next.res_addr  = itf.op_addr;
			r_next.res_skip  = 1'b0;
			case (itf.op)
				cfi_pkg::OP_ARITH: begin
					// Old carry goes back as carry-in; the adder's outcome becomes the new one
					r_next.res_true = r_reg.carry; // R07
					r_next.carry    = itf.op_carry; // R06
				end
				cfi_pkg::OP_CARRY_SET: begin
					r_next.carry = 1'b1; // R07
				end
				cfi_pkg::OP_CARRY_CLEAR: begin
					r_next.carry = 1'b0; // R07
				end
				cfi_pkg::OP_WORD_SET: begin
					// Only the selected bits move; bit 3 has no flag behind it
					r_next.bank  = mask_apply(r_reg.bank, itf.op_arg[cfi_pkg::GRP_BIT], 1'b1); // R24
					r_next.carry = mask_apply(r_reg.carry, itf.op_arg[cfi_pkg::CARRY_BIT], 1'b1); // R21
					r_next.inte  = mask_apply(r_reg.inte, itf.op_arg[cfi_pkg::INTE_BIT], 1'b1); // R21
				end
				cfi_pkg::OP_WORD_CLEAR: begin
					r_next.bank  = mask_apply(r_reg.bank, itf.op_arg[cfi_pkg::GRP_BIT], 1'b0); // R24
					r_next.carry = mask_apply(r_reg.carry, itf.op_arg[cfi_pkg::CARRY_BIT], 1'b0); // R21
					r_next.inte  = mask_apply(r_reg.inte, itf.op_arg[cfi_pkg::INTE_BIT], 1'b0); // R21
					req_clear    = itf.op_arg[cfi_pkg::INTE_BIT] & ~r_reg.inte; // R14
				end
				cfi_pkg::OP_GROUP_LO: begin
					r_next.bank = 1'b0; // R09
				end
				cfi_pkg::OP_GROUP_HI: begin
					r_next.bank = 1'b1; // R09
				end
				cfi_pkg::OP_IRQ_EN: begin
					r_next.inte = 1'b1; // R21
				end
				cfi_pkg::OP_IRQ_DIS: begin
					r_next.inte = 1'b0;
					req_clear   = ~r_reg.inte; // R14
				end
				cfi_pkg::OP_PULSE_TEST: begin
					r_next.res_true = r_reg.pulse; // R02
				end
				cfi_pkg::OP_UNLOCK_TEST: begin
					// Returns the flag and clears it; a pulse in this cycle still sets it
					r_next.res_true = r_reg.unlock; // R04
				end
				cfi_pkg::OP_PIN_TEST_T: begin
					r_next.res_true = ~pin_eff; // R19
				end
				cfi_pkg::OP_PIN_TEST_F: begin
					r_next.res_true = pin_eff; // R19
				end
				cfi_pkg::OP_FLAG_TEST_T: begin
					r_next.res_true = |(rd_word & itf.op_arg); // R22
				end
				cfi_pkg::OP_FLAG_TEST_F: begin
					r_next.res_true = ~|(rd_word & itf.op_arg); // R22
				end
				cfi_pkg::OP_GROUP_TEST: begin
					r_next.res_true = ~r_reg.bank;
				end
				cfi_pkg::OP_PORT_SEL: begin
					r_next.port_sel = {r_reg.bank, itf.op_arg[1:0]}; // R09
				end
				cfi_pkg::OP_CALL: begin
					// Subroutine and interrupt share the same three levels
					if (r_reg.sp == cfi_pkg::SP_FULL) begin
						r_next.stk_err = 1'b1; // R23
					end else begin
						r_next.stk_addr[r_reg.sp] = itf.op_addr;
						r_next.stk_skip[r_reg.sp] = 1'b0;
						r_next.sp = r_reg.sp + 2'h1; // R18
					end
				end
				cfi_pkg::OP_RETURN: begin
					r_next.res_addr = pop_addr; // R17
					r_next.res_skip = pop_skip; // R17
					push_addr       = pop_addr;
					if (r_reg.sp == 2'h0) begin
						r_next.stk_err = 1'b1;
					end else begin
						r_next.sp = r_reg.sp - 2'h1; // R17
					end
				end
				default: begin
					r_next.res_true = 1'b0;
				end
			endcase

			// Accept at the instruction boundary; carry and group flag are left alone
			if (r_next.inte && r_reg.int_req) begin // R13 R08
				accept          = 1'b1;
				r_next.inte     = 1'b0; // R15
				r_next.res_irq  = 1'b1;
				r_next.res_addr = cfi_pkg::INT_VECTOR; // R15
				if (r_next.sp == cfi_pkg::SP_FULL) begin
					r_next.stk_err = 1'b1; // R23
				end else begin
					r_next.stk_addr[r_next.sp] = push_addr; // R15
					r_next.stk_skip[r_next.sp] = itf.op_skip; // R16
					r_next.sp = r_next.sp + 2'h1; // R18
				end
			end
		end

		// Unlock flag: a pulse in the test cycle wins over the clear
		if (itf.op_valid && itf.op == cfi_pkg::OP_UNLOCK_TEST) begin
			r_next.unlock = 1'b0; // R04
		end
		if (unlock_pulse) begin
			r_next.unlock = 1'b1; // R03
		end

		// Request flag: a new edge wins over clearing and acceptance
		r_next.int_req = (r_reg.int_req & ~req_clear & ~accept) | int_edge; // R12

		// Chip-enable rise forces the lower group, overriding any op this cycle
		if (ce_pin && !r_reg.ce_prev) begin
			r_next.bank = 1'b0; // R10
		end
	end

	// All state in one register; reset also clears the group flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg         <= '0; // R10
			r_reg.pulse   <= 1'b1;
			r_reg.pin_prev <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from flops, except flag_read_word, which passes the live ce_pin and pin levels
	assign interval_pulse = r_reg.pulse;
	assign port_sel       = r_reg.port_sel;
	assign flag_read_word = rd_word;
	assign stack_err      = r_reg.stk_err;
	assign itf.res_valid  = r_reg.res_valid;
	assign itf.res_true   = r_reg.res_true;
	assign itf.res_skip   = r_reg.res_skip;
	assign itf.res_irq    = r_reg.res_irq;
	assign itf.res_addr   = r_reg.res_addr;
endmodule

//--- common/cfi_pkg.sv
// Constants, types and command encodings shared by both ends of the flag block.
// Assumes a single 10 MHz clock (pclk) and an active-low asynchronous reset.
// Overview of operation
// R01: Internal 5 ms pulse, 60 percent high.
// R02: Pulse test only samples the live level.
// R03: Unlock pulses arrive once per reference period.
// R04: Unlock pulse sets flag; unlock test clears it.
// R05: Software spaces unlock tests beyond reference period.
// R06: Arithmetic sets carry on carry, else clears.
// R07: Carry changes only by arithmetic or direct ops.
// R08: Interrupt entry saves neither carry nor group flag.
// R09: Two operand bits plus group flag choose port.
// R10: Group flag cleared at reset and CE rise.
// R11: Software returns to lower group before memory.
// R12: Falling interrupt pin edge always sets request.
// R13: Request accepted only while interrupt enable set.
// R14: Disable while disabled clears pending request.
// R15: Accept clears enable, pushes address, vectors to 1.
// R16: Skip decision is pushed with return address.
// R17: Return pops address and saved skip decision.
// R18: Interrupt entry uses one shared stack level.
// R19: Pin test true for low, false high.
// R20: Low pin reads high until seen high.
// R21: Write word: bit2 group, bit1 carry, bit0 enable.
// R22: Read word: bit2 group, bit1 CE, bit0 pin.
// R23: Return stack holds three levels in total.
// R24: Set and clear touch only masked bits.
package cfi_pkg;
	// Program address and stack shape
	localparam int           ADDR_W      = 11;
	localparam int           STACK_DEPTH = 3;
	localparam logic [10:0]  INT_VECTOR  = 11'h001;
	localparam logic [1:0]   SP_FULL     = 2'h3;

	// Status word bit positions
	localparam int           GRP_BIT     = 2;
	localparam int           CARRY_BIT   = 1;
	localparam int           INTE_BIT    = 0;
	localparam int           CE_BIT      = 1;
	localparam int           PIN_BIT     = 0;

	// Interval pulse timing
	localparam int           CLK_NS        = 100;
	localparam int           INTERVAL_US   = 5000;
	localparam int           DUTY_PCT      = 60;
	localparam int           INTERVAL_CYC  = INTERVAL_US * 1000 / CLK_NS;
	localparam int           HIGH_CYC      = INTERVAL_CYC * DUTY_PCT / 100;

	// APB register offsets of the execution-unit end
	localparam logic [11:0]  CMD_OFS     = 12'h000;
	localparam logic [11:0]  STAT_OFS    = 12'h004;

	// Command register fields
	localparam int           CMD_OP_LSB   = 0;
	localparam int           CMD_ARG_LSB  = 5;
	localparam int           CMD_CARRY    = 9;
	localparam int           CMD_SKIP     = 10;
	localparam int           CMD_ADDR_LSB = 16;

	// Status register fields
	localparam int           ST_TRUE      = 0;
	localparam int           ST_SKIP      = 1;
	localparam int           ST_IRQ       = 2;
	localparam int           ST_DONE      = 3;
	localparam int           ST_ADDR_LSB  = 16;

	// Operations issued by the execution unit
	typedef enum logic [4:0] {
		OP_NOP,
		OP_ARITH,
		OP_CARRY_SET,
		OP_CARRY_CLEAR,
		OP_WORD_SET,
		OP_WORD_CLEAR,
		OP_GROUP_LO,
		OP_GROUP_HI,
		OP_IRQ_EN,
		OP_IRQ_DIS,
		OP_PULSE_TEST,
		OP_UNLOCK_TEST,
		OP_PIN_TEST_T,
		OP_PIN_TEST_F,
		OP_FLAG_TEST_T,
		OP_FLAG_TEST_F,
		OP_GROUP_TEST,
		OP_PORT_SEL,
		OP_CALL,
		OP_RETURN
	} cfi_op_t;
endpackage

//--- common/cfi_if.sv
// Link between the flag block and the instruction execution unit.
// Both ends run on the same pclk; the bench joins them through this interface.
interface cfi_if;
	cfi_pkg::cfi_op_t op;
	logic             op_valid;
	logic [3:0]       op_arg;
	logic             op_carry;
	logic             op_skip;
	logic [10:0]      op_addr;
	logic             res_valid;
	logic             res_true;
	logic             res_skip;
	logic             res_irq;
	logic [10:0]      res_addr;

	modport dev (
		input  op, op_valid, op_arg, op_carry, op_skip, op_addr,
		output res_valid, res_true, res_skip, res_irq, res_addr
	);
	modport cpu (
		output op, op_valid, op_arg, op_carry, op_skip, op_addr,
		input  res_valid, res_true, res_skip, res_irq, res_addr
	);
endinterface

//--- rtl/cfi_exec.sv
// Execution-unit end: takes flag operations from software over APB and reports results.
// Assumes an APB master with 32-bit data; the flag block answers one cycle after each op.
module cfi_exec (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   psel,
	input  wire logic   penable,
	input  wire logic   pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	cfi_if.cpu          itf
);
	typedef struct packed {
		logic             op_valid;
		cfi_pkg::cfi_op_t op;
		logic [3:0]       arg;
		logic             carry;
		logic             skip;
		logic [10:0]      addr;
		logic             st_true;
		logic             st_skip;
		logic             st_irq;
		logic             st_done;
		logic [10:0]      st_addr;
		logic [31:0]      rdata;
	} cfi_exec_t;

	cfi_exec_t r_reg;
	cfi_exec_t r_next;

	logic mapped;
	logic wr_cmd;

	// Only the two words are mapped; anything else errors in the access phase
	assign mapped = (paddr == cfi_pkg::CMD_OFS) || (paddr == cfi_pkg::STAT_OFS);
	assign wr_cmd = psel & penable & pwrite & (paddr == cfi_pkg::CMD_OFS);

	always_comb begin
		r_next          = r_reg;
		r_next.op_valid = 1'b0;

		// Command write issues one op; done clears until the answer returns
		if (wr_cmd) begin
			r_next.op_valid = 1'b1;
			r_next.op       = cfi_pkg::cfi_op_t'(pwdata[cfi_pkg::CMD_OP_LSB +: 5]);
			r_next.arg      = pwdata[cfi_pkg::CMD_ARG_LSB +: 4]; // R24
			r_next.carry    = pwdata[cfi_pkg::CMD_CARRY]; // R06
			r_next.skip     = pwdata[cfi_pkg::CMD_SKIP]; // R16
			r_next.addr     = pwdata[cfi_pkg::CMD_ADDR_LSB +: 11];
			r_next.st_done  = 1'b0;
		end

		// Capture the answer; a vector or popped address steers the fetch
		if (itf.res_valid) begin
			r_next.st_true = itf.res_true;
			r_next.st_skip = itf.res_skip; // R17
			r_next.st_irq  = itf.res_irq; // R15
			r_next.st_addr = itf.res_addr;
			r_next.st_done = 1'b1;
		end

		// Read data is prepared in the setup cycle so it stands during access
		if (psel && !penable) begin
			r_next.rdata = 32'h0000_0000;
			if (paddr == cfi_pkg::STAT_OFS) begin
				r_next.rdata[cfi_pkg::ST_TRUE]          = r_reg.st_true;
				r_next.rdata[cfi_pkg::ST_SKIP]          = r_reg.st_skip;
				r_next.rdata[cfi_pkg::ST_IRQ]           = r_reg.st_irq;
				r_next.rdata[cfi_pkg::ST_DONE]          = r_reg.st_done;
				r_next.rdata[cfi_pkg::ST_ADDR_LSB +: 11] = r_reg.st_addr;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg         <= '0;
			r_reg.st_done <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Zero-wait slave
	assign pready       = 1'b1;
	assign pslverr      = psel & penable & ~mapped;
	assign prdata       = r_reg.rdata;
	assign itf.op_valid = r_reg.op_valid;
	assign itf.op       = r_reg.op;
	assign itf.op_arg   = r_reg.arg;
	assign itf.op_carry = r_reg.carry;
	assign itf.op_skip  = r_reg.skip;
	assign itf.op_addr  = r_reg.addr;
endmodule

//--- dv/cfi_checker.sv
// Link checker: watches where the flag block meets the execution unit.
// Instantiated by the bench beside the interface; sees only the link signals.
module cfi_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input cfi_pkg::cfi_op_t op,
	input wire logic        op_valid,
	input wire logic        op_skip,
	input wire logic [10:0] op_addr,
	input wire logic        res_valid,
	input wire logic        res_true,
	input wire logic        res_skip,
	input wire logic        res_irq,
	input wire logic [10:0] res_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, so clock and reset are given once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Two ops as the bus spaces them; the first must not have been an accept
	sequence pair_s(a, b);
		op_valid && op == a ##1 !op_valid && !res_irq ##1 !op_valid ##1 op_valid && op == b;
	endsequence

	link_answer_a: assert property (op_valid |=> res_valid)
		else $error("no answer one cycle after an op");
	link_quiet_a: assert property (!op_valid |=> !res_valid)
		else $error("answer seen without an op");
	accept_vector_a: assert property (res_irq |-> res_valid && res_addr == 11'h001)
		else $error("accept not vectored to address one");
	disable_blocks_a: assert property (op_valid && op == cfi_pkg::OP_IRQ_DIS |=> !res_irq)
		else $error("accept on a disable op");
	stay_disabled_a: assert property (op_valid && op == cfi_pkg::OP_IRQ_DIS ##1 !op_valid [*2]
		##1 op_valid && !(op inside {cfi_pkg::OP_IRQ_EN, cfi_pkg::OP_WORD_SET}) |=> !res_irq)
		else $error("accept while still disabled");
	lower_test_a: assert property (pair_s(cfi_pkg::OP_GROUP_LO, cfi_pkg::OP_GROUP_TEST)
		|=> res_true)
		else $error("lower group not reported");
	upper_test_a: assert property (pair_s(cfi_pkg::OP_GROUP_HI, cfi_pkg::OP_GROUP_TEST)
		|=> !res_true)
		else $error("upper group reported as lower");
	call_return_a: assert property (pair_s(cfi_pkg::OP_CALL, cfi_pkg::OP_RETURN)
		|=> res_irq || res_addr == $past(op_addr, 4) && !res_skip) // a call saves no skip
		else $error("return lost address or skip");

	// Main scenarios reached
	cover property (res_irq);
	cover property (pair_s(cfi_pkg::OP_CALL, cfi_pkg::OP_RETURN));
	cover property (op_valid && op == cfi_pkg::OP_UNLOCK_TEST ##1 res_true);
endmodule

//--- dv/tb_cpu_flags_and_interrupt.sv
// Bench for the flag block and execution unit joined back to back.
// Orders go in over APB; each expected link result is queued and retired.
module tb_cpu_flags_and_interrupt;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, irq_pin_n, ce_pin, unlock_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        pready, pslverr, er, s, interval_pulse, stack_err;
	logic [2:0]  port_sel;
	logic [3:0]  flag_read_word;
	logic [10:0] a;
	logic [13:0] m, v;
	logic [13:0] msk_q[$];
	logic [13:0] val_q[$];
	int          miscompares, num_checks, n;

	cfi_if itf();
	cfi_flags #(.PERIOD_CYC(10), .HIGH_CYC(6)) i_cfi_flags (.pclk(pclk), .presetn(presetn),
		.itf(itf), .irq_pin_n(irq_pin_n), .ce_pin(ce_pin), .unlock_pulse(unlock_pulse),
		.interval_pulse(interval_pulse), .port_sel(port_sel),
		.flag_read_word(flag_read_word), .stack_err(stack_err));
	cfi_exec i_cfi_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .itf(itf));
	cfi_checker i_cfi_checker (.pclk(pclk), .presetn(presetn), .op(itf.op),
		.op_valid(itf.op_valid), .op_skip(itf.op_skip), .op_addr(itf.op_addr),
		.res_valid(itf.res_valid), .res_true(itf.res_true), .res_skip(itf.res_skip),
		.res_irq(itf.res_irq), .res_addr(itf.res_addr));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Queue the note first so the result can never overtake it
	task automatic op(input cfi_pkg::cfi_op_t o, input logic [3:0] g, input logic sk,
		input logic [10:0] ad, input logic [13:0] mk, input logic [13:0] vl);
		msk_q.push_back(mk);
		val_q.push_back(vl);
		apb(1'b1, cfi_pkg::CMD_OFS, {5'h00, ad, 5'h00, sk, 1'b0, g, o});
	endtask

	task automatic run(input cfi_pkg::cfi_op_t o, input logic [3:0] g);
		op(o, g, 1'b0, 11'h000, 14'h2000, 14'h0000);
	endtask

	task automatic tst(input cfi_pkg::cfi_op_t o, input logic [3:0] g, input logic t);
		op(o, g, 1'b0, 11'h000, 14'h2800, {2'b00, t, 11'h000});
	endtask

	task automatic w(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// High first, so the pin history counts it as a real falling edge
	task automatic pin_fall();
		irq_pin_n <= 1'b1;
		w(2);
		irq_pin_n <= 1'b0;
		w(3);
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Arithmetic op: hands in the new carry, expects the old one back
	task automatic ari(input logic cy, input logic t);
		msk_q.push_back(14'h2800);
		val_q.push_back({2'b00, t, 11'h000});
		apb(1'b1, cfi_pkg::CMD_OFS, {22'h000000, cy, 4'h0, cfi_pkg::OP_ARITH});
	endtask

	task automatic rnd();
		seed = lfsr(seed);
		a = seed[10:0];
		s = seed[11];
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Each result on the link retires the oldest note
	always @(posedge pclk) begin
		if (itf.res_valid === 1'b1) begin
			m = msk_q.pop_front();
			v = val_q.pop_front();
			cmp("link_result", {18'h0, v & m},
				{18'h0, m & {itf.res_irq, itf.res_skip, itf.res_true, itf.res_addr}});
		end
	end

	// Cuts a hang short; the tests need well under a thousand cycles
	initial begin
		w(20000);
		miscompares++;
		summarize();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, irq_pin_n, ce_pin, unlock_pulse} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		seed = 32'h0001540e;
		w(3);
		presetn <= 1'b1;
		cmp("read_word", 32'h0, flag_read_word);
		cmp("port_sel", 32'h0, port_sel);
		tst(cfi_pkg::OP_PIN_TEST_T, 4'h0, 1'b0);
		pin_fall();
		tst(cfi_pkg::OP_PIN_TEST_T, 4'h0, 1'b1);
		tst(cfi_pkg::OP_PIN_TEST_F, 4'h0, 1'b0);
		cmp("read_word", 32'h1, flag_read_word);
		rnd();
		op(cfi_pkg::OP_IRQ_EN, 4'h0, s, a, 14'h23ff, 14'h2001);
		op(cfi_pkg::OP_RETURN, 4'h0, 1'b0, 11'h000, 14'h37ff, {1'b0, s, 1'b0, a});
		pin_fall();
		run(cfi_pkg::OP_IRQ_DIS, 4'h0);
		run(cfi_pkg::OP_IRQ_EN, 4'h0);
		run(cfi_pkg::OP_IRQ_DIS, 4'h0);
		run(cfi_pkg::OP_GROUP_HI, 4'h0);
		tst(cfi_pkg::OP_GROUP_TEST, 4'h0, 1'b0);
		run(cfi_pkg::OP_PORT_SEL, 4'h3);
		w(3);
		cmp("port_sel", 32'h7, port_sel);
		cmp("read_word", 32'h5, flag_read_word);
		ce_pin <= 1'b1;
		w(3);
		cmp("read_word", 32'h3, flag_read_word);
		run(cfi_pkg::OP_GROUP_LO, 4'h0);
		tst(cfi_pkg::OP_GROUP_TEST, 4'h0, 1'b1);
		run(cfi_pkg::OP_WORD_SET, 4'h4);
		w(3);
		cmp("read_word", 32'h7, flag_read_word);
		tst(cfi_pkg::OP_FLAG_TEST_T, 4'h4, 1'b1);
		run(cfi_pkg::OP_WORD_CLEAR, 4'h4);
		tst(cfi_pkg::OP_FLAG_TEST_F, 4'h4, 1'b1);
		tst(cfi_pkg::OP_FLAG_TEST_T, 4'h8, 1'b0);
		w(2);
		apb(1'b0, cfi_pkg::STAT_OFS, 32'h0);
		cmp("status", 32'h8, rd & 32'h9);
		apb(1'b0, 12'h008, 32'h0);
		cmp("slverr", 32'h1, er);
		cmp("unmapped", 32'h0, rd);
		unlock_pulse <= 1'b1;
		w(1);
		unlock_pulse <= 1'b0;
		tst(cfi_pkg::OP_UNLOCK_TEST, 4'h0, 1'b1);
		tst(cfi_pkg::OP_UNLOCK_TEST, 4'h0, 1'b0);
		rnd();
		op(cfi_pkg::OP_CALL, 4'h0, s, a, 14'h37ff, {3'b000, a});
		op(cfi_pkg::OP_RETURN, 4'h0, 1'b0, 11'h000, 14'h37ff, {3'b000, a});
		n = 0;
		repeat (10) begin
			@(posedge pclk);
			if (interval_pulse === 1'b1)
				n++;
		end
		cmp("pulse_high", 32'd6, n);
		// Line up with a rising pulse; the tests then land at counts 4 and 7
		while (interval_pulse !== 1'b0)
			@(posedge pclk);
		while (interval_pulse !== 1'b1)
			@(posedge pclk);
		tst(cfi_pkg::OP_PULSE_TEST, 4'h0, 1'b1);
		tst(cfi_pkg::OP_PULSE_TEST, 4'h0, 1'b0);
		run(cfi_pkg::OP_CARRY_SET, 4'h0);
		ari(1'b0, 1'b1);
		ari(1'b1, 1'b0);
		run(cfi_pkg::OP_WORD_CLEAR, 4'h2);
		ari(1'b1, 1'b0);
		run(cfi_pkg::OP_CARRY_CLEAR, 4'h0);
		run(cfi_pkg::OP_WORD_SET, 4'h6);
		pin_fall();
		op(cfi_pkg::OP_IRQ_EN, 4'h0, s, a, 14'h2000, 14'h2000);
		ari(1'b1, 1'b1);
		cmp("read_word", 32'h7, flag_read_word);
		run(cfi_pkg::OP_CALL, 4'h0);
		run(cfi_pkg::OP_CALL, 4'h0);
		w(3);
		cmp("stack_err", 32'h0, stack_err);
		run(cfi_pkg::OP_CALL, 4'h0);
		w(3);
		cmp("stack_err", 32'h1, stack_err);
		summarize();
	end
endmodule
